//--- rtl/tx_line_pkg.sv
// Shared constants and types for the transmit system interface and encoder.
// Assumes a 100 MHz hclk and an AHB-Lite register port carrying 32-bit words.
package tx_line_pkg;

  // Register indices; the byte address of each is four times its index
  localparam logic [7:0] IDX_TX_IFACE = 8'h02;
  localparam logic [7:0] IDX_TX_PULSE = 8'h03;
  localparam logic [7:0] IDX_STATUS   = 8'h04;
  localparam logic [7:0] IDX_GLOBAL   = 8'h40;

  // Field positions in tx_interface_config
  localparam int BIT_CODING_SEL = 0;
  localparam int BIT_RAIL_MODE  = 1;
  localparam int BIT_DATA_INV   = 2;
  localparam int BIT_EDGE_SEL   = 3;

  // Field positions in global_mode_config and in the status register
  localparam int BIT_STD_SEL    = 0;
  localparam int BIT_MISS_FLAG  = 0;
  localparam int BIT_MISS_MASK  = 1;
  localparam int BIT_CLK_ALIVE  = 2;

  // Values after reset
  localparam logic [3:0] RST_TX_IFACE = 4'h0;
  localparam logic [3:0] RST_TX_PULSE = 4'h0;
  localparam logic       RST_STD_SEL  = 1'h0;
  localparam logic       RST_MASK     = 1'h0;

  // Master clock cycles without a line clock edge that are still tolerated
  localparam logic [6:0] MISS_CLK_LIMIT = 7'h46;

  // Encoder look-ahead; eight zeros is the longest substituted run
  localparam int ENC_DEPTH = 8;

  typedef enum logic [1:0] {
    CODE_AMI  = 2'b00,
    CODE_B8ZS = 2'b01,
    CODE_HDB3 = 2'b10
  } coding_t;

  typedef enum logic [1:0] {
    SYM_ZERO = 2'b00,
    SYM_MARK = 2'b01,
    SYM_VIOL = 2'b10
  } sym_t;

  typedef enum logic [1:0] {
    SHAPE_PRESET    = 2'b00,
    SHAPE_BUILD_OUT = 2'b01,
    SHAPE_ARB       = 2'b10
  } shape_t;

  // One line symbol: pos is a positive pulse, neg a negative one
  typedef struct packed {
    logic pos;
    logic neg;
  } rail_pair_t;

endpackage

//--- rtl/line_encoder.sv
// Single-rail line encoder: AMI with optional B8ZS or HDB3 substitution.
// Assumes bit_en is a one-cycle pulse per data bit from the same clock.
`timescale 1ns/1ns
`default_nettype none
module line_encoder
  import tx_line_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       bit_en,
  input  wire logic       data_bit,
  input  wire coding_t    coding,
  output rail_pair_t      symbol
);

  typedef struct packed {
    sym_t [ENC_DEPTH-1:0] pipe;
    logic                 last_pos;
    logic                 odd_marks;
    rail_pair_t           out;
  } enc_state_t;

  enc_state_t st;
  enc_state_t next_st;

  // True when the newest n slots hold plain zeros
  function automatic logic all_zero(input sym_t [ENC_DEPTH-1:0] p, input int n);
    logic z;
    z = 1'b1;
    for (int i = 0; i < ENC_DEPTH; i++) begin
      if (i < n && p[i] != SYM_ZERO) begin
        z = 1'b0;
      end
    end
    return z;
  endfunction

  // Substitution is decided at the input end, polarity at the output end;
  // order is kept, so a violation always repeats the pulse just before it
  always_comb begin
    sym_t [ENC_DEPTH-1:0] p;
    p = st.pipe;
    next_st = st;
    if (bit_en) begin
      case (st.pipe[ENC_DEPTH-1])
        SYM_MARK: begin
          next_st.last_pos = !st.last_pos;
          next_st.out = '{pos: !st.last_pos, neg: st.last_pos};
        end
        SYM_VIOL: begin
          next_st.out = '{pos: st.last_pos, neg: !st.last_pos};
        end
        default: begin
          next_st.out = '{pos: 1'b0, neg: 1'b0};
        end
      endcase
      for (int i = ENC_DEPTH-1; i > 0; i--) begin
        p[i] = st.pipe[i-1];
      end
      p[0] = data_bit ? SYM_MARK : SYM_ZERO;
      if (coding == CODE_B8ZS && all_zero(p, 8)) begin
        // Eight zeros become 000VB0VB, oldest first
        p[4] = SYM_VIOL;
        p[3] = SYM_MARK;
        p[1] = SYM_VIOL;
        p[0] = SYM_MARK;
      end else if (coding == CODE_HDB3 && all_zero(p, 4)) begin
        // Four zeros become 000V or B00V to keep violations alternating
        if (!st.odd_marks) begin
          p[3] = SYM_MARK;
        end
        p[0] = SYM_VIOL;
        next_st.odd_marks = 1'b0;
      end else if (p[0] == SYM_MARK) begin
        next_st.odd_marks = !st.odd_marks;
      end
      next_st.pipe = p;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign symbol = st.out;

  // Plain marks leave with the polarity opposite to the pulse before
  a_mark_alternates: assert property (@(posedge hclk) disable iff (!hresetn)
    (bit_en && st.pipe[ENC_DEPTH-1] == SYM_MARK) |=> (st.out.pos == !$past(st.last_pos)))
    else $error("mark did not alternate polarity");

endmodule
`default_nettype wire

//--- rtl/tx_line_interface.sv
// Transmit system interface of one line channel: line clock sampling,
// rail and polarity selection, encoder, missing-clock watch, pulse select.
// Assumes one AHB-Lite master; line clock and data pins are asynchronous.
`timescale 1ns/1ns
`default_nettype none

module tx_line_interface
  import tx_line_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        tx_line_clock,
  input  wire logic        tx_data_pos_rail,
  input  wire logic        tx_data_neg_rail,
  output logic             line_pos_pulse,
  output logic             line_neg_pulse,
  output logic             line_standard_select,
  output logic [3:0]       pulse_template_select,
  output shape_t           shaper_method,
  output logic [1:0]       build_out_grade,
  output logic             miss_clock_irq
);

  typedef struct packed {
    // Pin synchronisers; index 0 is the first flop
    logic [2:0]  clk_s;
    logic [1:0]  pos_s;
    logic [1:0]  neg_s;
    // Software controls
    logic [3:0]  iface;
    logic [3:0]  pulse;
    logic        std_sel;
    logic        miss_mask;
    // Channel state
    logic        miss_flag;
    logic [6:0]  miss_cnt;
    logic        bit_en;
    logic        data_bit;
    logic        dp;
    logic        dn;
    // Registered outputs
    logic        line_pos;
    logic        line_neg;
    logic        std_out;
    logic [3:0]  tmpl;
    shape_t      shape;
    logic [1:0]  grade;
    logic        irq;
    // Bus slave
    logic        ph_valid;
    logic        ph_write;
    logic [23:0] ph_word;
    logic        rdy;
    logic [7:0]  rdata;
  } ch_state_t;

  ch_state_t  st;
  ch_state_t  next_st;
  rail_pair_t enc_symbol;
  coding_t    coding;
  logic       edge_any;
  logic       edge_act;

  // Register contents as seen by a read; unmapped words read as zero
  function automatic logic [7:0] read_word(input ch_state_t s, input logic [23:0] w);
    logic [7:0] r;
    r = 8'h00;
    if (w == {16'h0000, IDX_TX_IFACE}) begin
      r = {4'h0, s.iface};
    end else if (w == {16'h0000, IDX_TX_PULSE}) begin
      r = {4'h0, s.pulse};
    end else if (w == {16'h0000, IDX_STATUS}) begin
      r[BIT_MISS_FLAG] = s.miss_flag;
      r[BIT_MISS_MASK] = s.miss_mask;
      r[BIT_CLK_ALIVE] = (s.miss_cnt != MISS_CLK_LIMIT);
    end else if (w == {16'h0000, IDX_GLOBAL}) begin
      r[BIT_STD_SEL] = s.std_sel;
    end
    return r;
  endfunction

  // Shaping method from the pulse-select field
  function automatic shape_t shape_of(input logic [3:0] t);
    shape_t m;
    if (t[3:2] == 2'b11) begin
      m = SHAPE_ARB;
    end else if (t[3:2] == 2'b10) begin
      m = SHAPE_BUILD_OUT;
    end else begin
      m = SHAPE_PRESET;
    end
    return m;
  endfunction

  // Edges are found between the second and third flops, never the first
  assign edge_any = st.clk_s[1] ^ st.clk_s[2];
  assign edge_act = edge_any && (st.clk_s[1] == !st.iface[BIT_EDGE_SEL]);

  // Coding bit 0 selects plain AMI; when clear, the standard picks which substitution
  always_comb begin
    if (st.iface[BIT_CODING_SEL]) begin
      coding = CODE_AMI;
    end else if (st.std_sel) begin
      coding = CODE_B8ZS;
    end else begin
      coding = CODE_HDB3;
    end
  end

  line_encoder encoder (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .bit_en   (st.bit_en && !st.iface[BIT_RAIL_MODE]),
    .data_bit (st.data_bit),
    .coding   (coding),
    .symbol   (enc_symbol)
  );

  // Whole next state of the channel and its bus slave
  always_comb begin
    logic clr_req;
    clr_req = 1'b0;
    next_st = st;

    // Pins pass two flops before any logic looks at them
    next_st.clk_s = {st.clk_s[1:0], tx_line_clock};
    next_st.pos_s = {st.pos_s[0], tx_data_pos_rail};
    next_st.neg_s = {st.neg_s[0], tx_data_neg_rail};

    // Sample on the chosen edge, with the chosen polarity
    next_st.bit_en = edge_act;
    if (edge_act) begin
      next_st.data_bit = st.pos_s[1] ^ st.iface[BIT_DATA_INV];
      next_st.dp = st.pos_s[1] ^ st.iface[BIT_DATA_INV];
      next_st.dn = st.neg_s[1] ^ st.iface[BIT_DATA_INV];
    end

    // Dual rail skips the encoder; a positive rail mark is a negative pulse
    if (st.iface[BIT_RAIL_MODE]) begin
      next_st.line_pos = !st.dp && st.dn;
      next_st.line_neg = st.dp && !st.dn;
    end else begin
      next_st.line_pos = enc_symbol.pos;
      next_st.line_neg = enc_symbol.neg;
    end

    // Counter saturates at the limit so a dead clock costs no power
    if (edge_any) begin
      next_st.miss_cnt = 7'h00;
    end else if (st.miss_cnt != MISS_CLK_LIMIT) begin
      next_st.miss_cnt = st.miss_cnt + 7'h01;
    end

    // Pulse shaping selection follows the software field
    next_st.std_out = st.std_sel;
    next_st.tmpl = st.pulse;
    next_st.shape = shape_of(st.pulse);
    next_st.grade = st.pulse[1:0];

    // Bus: writes land in the data phase; reads wait one cycle for data
    if (st.rdy) begin
      if (st.ph_valid && st.ph_write) begin
        if (st.ph_word == {16'h0000, IDX_TX_IFACE}) begin
          next_st.iface = hwdata[3:0];
        end else if (st.ph_word == {16'h0000, IDX_TX_PULSE}) begin
          next_st.pulse = hwdata[3:0];
        end else if (st.ph_word == {16'h0000, IDX_STATUS}) begin
          clr_req = hwdata[BIT_MISS_FLAG];
          next_st.miss_mask = hwdata[BIT_MISS_MASK];
        end else if (st.ph_word == {16'h0000, IDX_GLOBAL}) begin
          next_st.std_sel = hwdata[BIT_STD_SEL];
        end
      end
      next_st.ph_valid = hready && hsel && htrans[1];
      next_st.ph_write = hwrite;
      next_st.ph_word = haddr[25:2];
      next_st.rdy = !(hready && hsel && htrans[1] && !hwrite);
    end else begin
      next_st.rdata = read_word(st, st.ph_word);
      next_st.rdy = 1'b1;
      next_st.ph_valid = 1'b0;
    end

    // A missing clock that appears while software clears still sticks
    if (st.miss_cnt == MISS_CLK_LIMIT && !edge_any) begin
      next_st.miss_flag = 1'b1;
    end else if (clr_req) begin
      next_st.miss_flag = 1'b0;
    end
    next_st.irq = st.miss_flag && !st.miss_mask;
  end

  // Only constants under reset; the controls start in E1, single rail
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.iface <= RST_TX_IFACE;
      st.pulse <= RST_TX_PULSE;
      st.std_sel <= RST_STD_SEL;
      st.miss_mask <= RST_MASK;
      st.rdy <= 1'b1;
      st.shape <= SHAPE_PRESET;
    end else begin
      st <= next_st;
    end
  end

  // Every output except hresp and the upper 24 bits of hrdata, which are tied low, is a flop of the state
  assign hreadyout = st.rdy;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, st.rdata};
  assign line_pos_pulse = st.line_pos;
  assign line_neg_pulse = st.line_neg;
  assign line_standard_select = st.std_out;
  assign pulse_template_select = st.tmpl;
  assign shaper_method = st.shape;
  assign build_out_grade = st.grade;
  assign miss_clock_irq = st.irq;

  // A write to the global register shows on the standard output two edges on
  a_std_follows_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.rdy && st.ph_valid && st.ph_write && st.ph_word == {16'h0000, IDX_GLOBAL})
    |-> ##2 (line_standard_select == $past(hwdata[BIT_STD_SEL], 2)))
    else $error("standard select did not follow the write");

  // The flag rises on the cycle after the limit is passed with no edge
  a_miss_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.miss_cnt == MISS_CLK_LIMIT && !edge_any) |=> st.miss_flag)
    else $error("missing clock not flagged");

  // The flag never rises while the line clock is still toggling in time
  a_miss_no_false: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(st.miss_flag) |-> $past(st.miss_cnt) == MISS_CLK_LIMIT)
    else $error("missing clock flagged too early");

  // A masked event never reaches the interrupt pin
  a_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.miss_mask || !st.miss_flag) |=> !miss_clock_irq)
    else $error("interrupt raised while masked or idle");

  // Samples are taken only on the selected edge
  a_edge_select: assert property (@(posedge hclk) disable iff (!hresetn)
    st.bit_en |-> ($past(st.clk_s[1]) != $past(st.clk_s[2]))
      && ($past(st.clk_s[1]) == !$past(st.iface[BIT_EDGE_SEL])))
    else $error("sample taken on the wrong edge");

  // Single rail data is the data pin with the selected polarity
  a_invert_data: assert property (@(posedge hclk) disable iff (!hresetn)
    st.bit_en |-> st.data_bit == ($past(st.pos_s[1]) ^ $past(st.iface[BIT_DATA_INV])))
    else $error("sampled data polarity wrong");

  // Single rail drives the line from the encoder only
  a_single_rail: assert property (@(posedge hclk) disable iff (!hresetn)
    !st.iface[BIT_RAIL_MODE] |=> ({line_pos_pulse, line_neg_pulse} == $past(enc_symbol)))
    else $error("single rail output not from encoder");

  // Dual rail maps the two rails straight to the opposite pulse polarity
  a_dual_rail_map: assert property (@(posedge hclk) disable iff (!hresetn)
    st.iface[BIT_RAIL_MODE] |=> (line_neg_pulse == $past(st.dp && !st.dn))
      && (line_pos_pulse == $past(!st.dp && st.dn)))
    else $error("dual rail pulse mapping wrong");

  // Pulse-select 11xx always picks the arbitrary waveform
  a_arb_select: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.pulse[3:2] == 2'b11) |=> (shaper_method == SHAPE_ARB))
    else $error("arbitrary waveform not selected");

  // A read costs exactly one wait state
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (st.rdy && hsel && htrans[1] && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_missing_clock: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(miss_clock_irq));
  c_dual_rail_pulse: cover property (@(posedge hclk) disable iff (!hresetn)
    st.iface[BIT_RAIL_MODE] && line_neg_pulse);
  c_encoded_mark: cover property (@(posedge hclk) disable iff (!hresetn)
    !st.iface[BIT_RAIL_MODE] && line_pos_pulse ##[1:40] line_neg_pulse);
  c_build_out: cover property (@(posedge hclk) disable iff (!hresetn)
    shaper_method == SHAPE_BUILD_OUT);

endmodule
`default_nettype wire

//--- dv/framer_model.sv
// Behavioural framer driving one transmit channel's clock and data pins.
// Assumes calls start off the hclk edges; the clock idles low between frames.
`timescale 1ns/1ns
`default_nettype none
module framer_model (
  output var logic tx_line_clock,
  output var logic tx_data_pos_rail,
  output var logic tx_data_neg_rail
);
  initial {tx_line_clock, tx_data_pos_rail, tx_data_neg_rail} = 3'h2;

  // One 80 ns bit. Data is valid from 20 ns before to 20 ns after the chosen edge, rising or falling,
  // so a receiver that samples on the wrong edge sees the inverse
  task automatic send_bit(input logic p, input logic n, input logic fall);
    tx_data_pos_rail = p ^ fall;
    tx_data_neg_rail = n ^ fall;
    #20 tx_line_clock = 1'h1;
    #20 tx_data_pos_rail = p ^ !fall;
    tx_data_neg_rail = n ^ !fall;
    #20 tx_line_clock = 1'h0;
    #20;
  endtask

  // Released lines flip rather than keep the last value
  task automatic idle_lines();
    tx_data_pos_rail = !tx_data_pos_rail;
    tx_data_neg_rail = !tx_data_neg_rail;
  endtask
endmodule
`default_nettype wire

//--- dv/tx_line_interface_tb.sv
// Bench for one transmit channel: registers, pulse decode, line coding and
// the missing-clock watch. Assumes framer_model drives the line-side pins.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, s) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t %s got %0h exp %0h", $time, s, g, e); end end
module tx_line_interface_tb
  import tx_line_pkg::*;
;
  localparam logic [31:0] A_IFACE = {22'h0, IDX_TX_IFACE, 2'h0};
  localparam logic [31:0] A_PULSE = {22'h0, IDX_TX_PULSE, 2'h0};
  localparam logic [31:0] A_STAT  = {22'h0, IDX_STATUS, 2'h0};
  localparam logic [31:0] A_GLOB  = {22'h0, IDX_GLOBAL, 2'h0};
  localparam logic [31:0] A_NONE  = 32'h14; // Unmapped word
  // Standard in bit 4, interface field below: AMI, HDB3, B8ZS, inverted and
  // falling-edge variants, then dual rail both ways
  localparam logic [4:0]  RUNS [7] = '{5'h01, 5'h00, 5'h10, 5'h1d, 5'h0c, 5'h12, 5'h0e};

  logic        hclk     = 1'h0;
  logic        hresetn  = 1'h0;
  logic        hsel     = 1'h0;
  logic        hwrite   = 1'h0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0;
  logic        hready, hreadyout, hresp, line_pos_pulse, line_neg_pulse;
  logic        tx_line_clock, tx_data_pos_rail, tx_data_neg_rail;
  logic        line_standard_select, miss_clock_irq;
  logic [31:0] hrdata, rd, d;
  logic [3:0]  pulse_template_select, p;
  logic [1:0]  build_out_grade;
  shape_t      shaper_method, sh;
  logic        mon_on   = 1'h0;
  logic        mon_fall = 1'h0;
  logic [1:0]  obs[$];
  int          bits[$], exp_s[$], m;
  int          checks    = 0;
  int          bad_count = 0;

  // 100 MHz clock
  always #5 hclk = ~hclk;

  // Device and framer; hready loops back from the one slave
  assign hready = hreadyout;
  tx_line_interface dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .tx_line_clock, .tx_data_pos_rail, .tx_data_neg_rail,
    .line_pos_pulse, .line_neg_pulse, .line_standard_select, .pulse_template_select,
    .shaper_method, .build_out_grade, .miss_clock_irq
  );
  framer_model partner (.tx_line_clock, .tx_data_pos_rail, .tx_data_neg_rail);

  // Sample the line outputs after each active edge has crossed the
  // synchroniser, well before the next bit (8 hclk apart)
  always @(tx_line_clock) begin
    if (mon_on && tx_line_clock !== mon_fall) begin
      repeat (6) @(posedge hclk);
      @(negedge hclk);
      obs.push_back({line_pos_pulse, line_neg_pulse});
    end
  end

  // Bus master: hold each phase until hready is seen high, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 40);
    if (n >= 40) begin
      bad_count++;
      $display("MISMATCH t=%0t bus hang", $time);
      wrap_up();
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    `CHK({hresp, rd}, {1'h0, e}, "read")
  endtask

  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (5) @(posedge hclk);
  endtask

  // Registered outputs follow a write two edges later
  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask

  function automatic logic [1:0] sym2(input int s);
    return s > 0 ? 2'h2 : s < 0 ? 2'h1 : 2'h0;
  endfunction

  // Reference coder: 0 AMI, 1 B8ZS, 2 HDB3. The look-ahead starts with
  // unchecked zeros; each later bit closes a window of k symbols that is
  // substituted when all are plain zeros. Codes: 0 zero, 1 mark, 2 violation.
  // First mark is positive, HDB3 parity starts even
  task automatic encode(input int code);
    int i, j, k, z, last, odd;
    int s[$];
    last = -1;
    odd = 0;
    k = (code == 1) ? 8 : 4;
    s = {};
    exp_s = {};
    for (i = 0; i < bits.size(); i++) begin
      s.push_back(bits[i]);
      z = (code != 0) && (i >= ENC_DEPTH);
      for (j = 0; j < k && z; j++) z = (s[i - j] == 0);
      if (z && code == 1) begin
        s[i - 4] = 2;
        s[i - 3] = 1;
        s[i - 1] = 2;
        s[i] = 1;
      end else if (z) begin
        if (!odd) s[i - 3] = 1;
        s[i] = 2;
        odd = 0;
      end else begin
        odd = odd ^ bits[i];
      end
    end
    // Marks alternate, violations repeat the pulse before them
    foreach (s[n]) begin
      if (s[n] == 1) last = -last;
      exp_s.push_back(s[n] != 0 ? last : 0);
    end
  endtask

  // One framed burst of 40 bits in one configuration, checked per symbol.
  // The negative rail is random in single rail too, where it must be ignored
  task automatic line_run(input logic [4:0] c);
    logic [1:0] r;
    logic [1:0] q[$];
    int n;
    do_reset();
    bus(1'h1, A_GLOB, {31'h0, c[4]});
    bus(1'h1, A_IFACE, {28'h0, c[3:0]});
    bits = {0, 0, 0, 0, 0, 0, 0, 0}; // Reset contents of the look-ahead
    for (n = 0; n < 40; n++) begin
      r = 2'($urandom);
      if (!c[1]) r[1] = c[2] ^ (($urandom % 3 == 0) && (n < 9 || n > 17));
      q.push_back(r);
      bits.push_back(r[1] ^ c[2]);
    end
    encode(c[0] ? 0 : c[4] ? 1 : 2);
    obs = {};
    mon_fall = c[3];
    mon_on = 1'h1;
    #3;
    foreach (q[i]) partner.send_bit(q[i][1], q[i][0], c[3]);
    partner.idle_lines();
    repeat (12) @(posedge hclk);
    mon_on = 1'h0;
    `CHK(obs.size(), 40, "symbol count")
    for (n = 0; n < obs.size(); n++) begin
      r = q[n] ^ {2{c[2]}};
      if (c[1]) begin
        `CHK(obs[n], r == 2'h2 ? 2'h1 : r == 2'h1 ? 2'h2 : 2'h0, "dual")
      end else begin
        `CHK(obs[n], sym2(exp_s[n]), "coded")
      end
    end
    $display("test line config %0h done", c);
  endtask

  // Missing line clock: flag and interrupt, clear during traffic, mask
  task automatic miss_test();
    do_reset();
    repeat (100) @(posedge hclk);
    #1;
    `CHK(miss_clock_irq, 1'h1, "irq after idle")
    fork
      begin
        #3;
        repeat (20) partner.send_bit(1'h1, 1'h0, 1'h0);
      end
      begin
        repeat (40) @(posedge hclk);
        bus(1'h1, A_STAT, 32'h1);
        bus(1'h0, A_STAT, 32'h0);
        `CHK(rd[1:0], 2'h0, "flag cleared")
      end
    join
    partner.idle_lines();
    repeat (50) @(posedge hclk);
    bus(1'h0, A_STAT, 32'h0);
    `CHK({rd[2], rd[0], miss_clock_irq}, 3'h4, "within limit")
    repeat (30) @(posedge hclk);
    bus(1'h0, A_STAT, 32'h0);
    `CHK({rd[2], rd[0], miss_clock_irq}, 3'h3, "limit passed")
    bus(1'h1, A_STAT, 32'h2);
    settle();
    `CHK(miss_clock_irq, 1'h0, "masked")
    $display("test missing clock done");
  endtask

  // Closing report and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h8202));
    do_reset();
    rd_chk(A_IFACE, {28'h0, RST_TX_IFACE});
    rd_chk(A_PULSE, {28'h0, RST_TX_PULSE});
    rd_chk(A_GLOB, {31'h0, RST_STD_SEL});
    d = $urandom & 32'hf;
    bus(1'h1, A_IFACE, d);
    rd_chk(A_IFACE, d);
    bus(1'h1, A_NONE, 32'hffffffff);
    rd_chk(A_NONE, 32'h0);
    $display("test registers done");
    // Every pulse-select code and its shaping decode
    for (m = 0; m < 16; m++) begin
      p = 4'(m);
      bus(1'h1, A_PULSE, {28'h0, p});
      settle();
      sh = p[3:2] == 2'h3 ? SHAPE_ARB : p[3:2] == 2'h2 ? SHAPE_BUILD_OUT : SHAPE_PRESET;
      `CHK(shaper_method, sh, "method")
      `CHK({pulse_template_select, build_out_grade}, {p, p[1:0]}, "template")
      rd_chk(A_PULSE, {28'h0, p});
    end
    $display("test pulse select done");
    for (m = 1; m >= 0; m--) begin
      bus(1'h1, A_GLOB, 32'(m));
      settle();
      `CHK(line_standard_select, 1'(m), "standard")
    end
    $display("test standard done");
    for (m = 0; m < 7; m++) line_run(RUNS[m]);
    miss_test();
    wrap_up();
  end
endmodule
`default_nettype wire
